// ==== hdl/fifo_read_side_consts.vh ====
// Constants for the read side of the dual-pointer word FIFO.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef FIFO_READ_SIDE_CONSTS_VH
`define FIFO_READ_SIDE_CONSTS_VH

// Register byte offsets
`define OFS_CTRL 4'h0
`define OFS_THRESH 4'h4
`define OFS_INITVAL 4'h8
`define OFS_STATUS 4'hc

// Control fields
`define CTRL_FWFT 0
`define CTRL_RESET 32'h0000_0000

// Status fields
`define ST_EMPTY 0
`define ST_NEAR 1
`define ST_FAULT 2
`define ST_CNT_LSB 8

// Reset values
`define THRESH_RESET 32'h0000_0001
`define INITVAL_RESET 32'h0000_0000

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/dual_clock_fifo_read_side.v ====
// Read side of a word FIFO whose pointers cross between domains,
// with request and fall-through output modes and a held output stage.
// Assumes writer and reader logic on mclk, registers over AXI4-Lite.
// Operation
// R01 - After first write into empty FIFO, empty drops 2-3 read cycles later.
// R02 - Fall-through mode shows first word when empty drops, no request.
// R03 - Near-empty compares word count to threshold; write effects lag 2-3 cycles.
// R04 - Read while empty is ignored; fault raised next cycle; output unchanged.
// R05 - Request mode: accepted read puts the removed word out one cycle later.
// R06 - Fall-through mode: read acknowledges shown word, next word replaces it.
// R07 - No request removes nothing; hold enable alone does not change output.
// R08 - Load-initial forces output register to initial value in either mode.
// R09 - Read with hold enable low keeps output, but word is still consumed.
// R10 - Flags assert at once; only de-assertion waits for synchronization.
// R11 - Fall-through mode adds one element of effective depth.
// R12 - Write pointer passes Gray-coded through two flip-flops to read side.
`timescale 1ns/1ps
`include "fifo_read_side_consts.vh"

module async_word_store #(
    parameter WIDTH = 32,
    parameter DEPTH = 4
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Fill side
    input wire wrValid,
    input wire [WIDTH-1:0] wrData,
    output wire wrReady,
    // Drain side
    output wire rdValid,
    input wire rdReady,
    output wire [WIDTH-1:0] rdData,
    output wire [$clog2(DEPTH):0] count
);
    localparam AW = $clog2(DEPTH);
    localparam [AW:0] FULL_CNT = DEPTH;

    function [AW:0] grayToBin;
        input [AW:0] g;
        integer i;
        begin
            grayToBin[AW] = g[AW];
            for (i = AW - 1; i >= 0; i = i - 1) begin
                grayToBin[i] = grayToBin[i + 1] ^ g[i];
            end
        end
    endfunction

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrBin_reg;
    reg [AW:0] wrGray_reg;
    reg [AW:0] rdBin_reg;
    reg [AW:0] rdGray_reg;
    reg [AW:0] wrSyncA_reg;
    reg [AW:0] wrSyncB_reg;
    reg [AW:0] rdSyncA_reg;
    reg [AW:0] rdSyncB_reg;
    reg wrReady_reg;

    wire push = wrValid & wrReady_reg;
    wire pop = rdReady & rdValid;
    wire [AW:0] wrBin_next = wrBin_reg + {{AW{1'b0}}, push};
    wire [AW:0] rdBin_next = rdBin_reg + {{AW{1'b0}}, pop};
    wire [AW:0] wrSeen = grayToBin(wrSyncB_reg);
    wire [AW:0] rdSeen = grayToBin(rdSyncB_reg);

    // Count uses the local read pointer, so a pop empties at once while a
    // push only shows after the pointer has crossed over
    assign count = wrSeen - rdBin_reg; // see R10
    assign rdValid = |count;
    assign rdData = mem[rdBin_reg[AW-1:0]];
    assign wrReady = wrReady_reg;

    always @(posedge clk) begin
        if (push) begin
            mem[wrBin_reg[AW-1:0]] <= wrData;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            wrBin_reg <= {(AW+1){1'b0}};
            wrGray_reg <= {(AW+1){1'b0}};
            rdBin_reg <= {(AW+1){1'b0}};
            rdGray_reg <= {(AW+1){1'b0}};
            wrSyncA_reg <= {(AW+1){1'b0}};
            wrSyncB_reg <= {(AW+1){1'b0}};
            rdSyncA_reg <= {(AW+1){1'b0}};
            rdSyncB_reg <= {(AW+1){1'b0}};
            wrReady_reg <= 1'b1;
        end else begin
            wrBin_reg <= wrBin_next;
            wrGray_reg <= wrBin_next ^ (wrBin_next >> 1); // see R12
            rdBin_reg <= rdBin_next;
            rdGray_reg <= rdBin_next ^ (rdBin_next >> 1);
            wrSyncA_reg <= wrGray_reg; // see R12
            wrSyncB_reg <= wrSyncA_reg; // see R01
            rdSyncA_reg <= rdGray_reg;
            rdSyncB_reg <= rdSyncA_reg;
            // Full asserts on the push that fills; frees show late
            wrReady_reg <= (wrBin_next - rdSeen) != FULL_CNT; // see R10
        end
    end
endmodule // async_word_store

module dual_clock_fifo_read_side #(
    parameter WIDTH = 32,
    parameter DEPTH = 4
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Fill stream
    input wire wrValid,
    input wire [WIDTH-1:0] wrData,
    output wire wrReady,
    // Read controls
    input wire rdReq,
    input wire holdEn,
    input wire loadInit,
    // Read outputs
    output wire [WIDTH-1:0] rdData,
    output wire emptyFlag,
    output wire nearEmptyFlag,
    output wire rdFault,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    localparam AW = $clog2(DEPTH);

    function [31:0] mergeBytes;
        input [31:0] old;
        input [31:0] din;
        input [3:0] strb;
        integer b;
        begin
            mergeBytes = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    mergeBytes[b*8 +: 8] = din[b*8 +: 8];
                end
            end
        end
    endfunction

    // Configuration registers
    reg [31:0] ctrl_reg;
    reg [31:0] thresh_reg;
    reg [31:0] initVal_reg;
    reg faultSticky_reg;
    // Output stage
    reg [WIDTH-1:0] rdData_reg;
    reg outValid_reg;
    reg empty_reg;
    reg nearEmpty_reg;
    reg rdFault_reg;
    // Bus state
    reg awready_reg;
    reg wready_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg arready_reg;
    reg rvalid_reg;
    reg [1:0] rresp_reg;
    reg [31:0] rdata_reg;
    reg [3:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire storeValid;
    wire [WIDTH-1:0] storeData;
    wire [AW:0] storeCount;
    wire fwftMode = ctrl_reg[`CTRL_FWFT];

    // Read-side decisions
    reg storePop;
    reg loadWord;
    reg outValid_next;
    reg empty_next;
    reg [AW+1:0] level_next;
    reg [WIDTH-1:0] rdData_next;

    async_word_store #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) store (
        .clk(mclk),
        .rstn(rstn),
        .wrValid(wrValid),
        .wrData(wrData),
        .wrReady(wrReady),
        .rdValid(storeValid),
        .rdReady(storePop),
        .rdData(storeData),
        .count(storeCount)
    );

    always @* begin
        if (fwftMode) begin
            // Output register is an extra slot, so depth grows by one
            outValid_next = storeValid | (outValid_reg & ~rdReq); // see R11
            storePop = storeValid & (~outValid_reg | rdReq); // see R06
            // Fall-through fill ignores hold enable; acknowledged refill obeys it
            loadWord = storePop & (~outValid_reg | holdEn); // see R02
            empty_next = ~outValid_next; // see R02
        end else begin
            outValid_next = 1'b0;
            storePop = rdReq & ~empty_reg & storeValid; // see R04
            loadWord = storePop & holdEn; // see R05 R09
            empty_next = (storeCount - {{AW{1'b0}}, storePop}) == {(AW+1){1'b0}};
        end
        level_next = {1'b0, storeCount} - {{(AW+1){1'b0}}, storePop}
            + {{(AW+1){1'b0}}, outValid_next};
        if (loadInit) begin
            rdData_next = initVal_reg[WIDTH-1:0]; // see R08
        end else if (loadWord) begin
            rdData_next = storeData;
        end else begin
            rdData_next = rdData_reg; // see R07
        end
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            rdData_reg <= {WIDTH{1'b0}};
            outValid_reg <= 1'b0;
            empty_reg <= 1'b1;
            nearEmpty_reg <= 1'b1;
            rdFault_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            outValid_reg <= outValid_next;
            empty_reg <= empty_next; // see R01 R10
            nearEmpty_reg <= {{(30-AW){1'b0}}, level_next} <= thresh_reg; // see R03
            rdFault_reg <= rdReq & empty_reg; // see R04
        end
    end

    // Write channel: address and data taken in either order, answered together
    wire doWrite = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire faultClr = doWrite && awaddr_reg == `OFS_STATUS && wstrb_reg[0]
        && wdata_reg[`ST_FAULT];

    always @(posedge mclk) begin
        if (!rstn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            ctrl_reg <= `CTRL_RESET;
            thresh_reg <= `THRESH_RESET;
            initVal_reg <= `INITVAL_RESET;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awaddr_reg <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (doWrite) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= `RESP_OKAY;
                case (awaddr_reg)
                    `OFS_CTRL: begin
                        ctrl_reg <= mergeBytes(ctrl_reg, wdata_reg, wstrb_reg)
                            & 32'h0000_0001;
                    end
                    `OFS_THRESH: begin
                        thresh_reg <= mergeBytes(thresh_reg, wdata_reg, wstrb_reg);
                    end
                    `OFS_INITVAL: begin
                        initVal_reg <= mergeBytes(initVal_reg, wdata_reg, wstrb_reg);
                    end
                    `OFS_STATUS: begin
                        bresp_reg <= `RESP_OKAY;
                    end
                    default: begin
                        bresp_reg <= `RESP_SLVERR;
                    end
                endcase
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // A fault in the clearing cycle survives the clear
    always @(posedge mclk) begin
        if (!rstn) begin
            faultSticky_reg <= 1'b0;
        end else if (rdReq && empty_reg) begin
            faultSticky_reg <= 1'b1; // see R04
        end else if (faultClr) begin
            faultSticky_reg <= 1'b0;
        end
    end

    // Read channel: one cycle from address to data
    always @(posedge mclk) begin
        if (!rstn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg <= `RESP_OKAY;
                rdata_reg <= 32'h0000_0000;
                case (s_axi_araddr)
                    `OFS_CTRL: rdata_reg <= ctrl_reg;
                    `OFS_THRESH: rdata_reg <= thresh_reg;
                    `OFS_INITVAL: rdata_reg <= initVal_reg;
                    `OFS_STATUS: begin
                        rdata_reg[`ST_EMPTY] <= empty_reg;
                        rdata_reg[`ST_NEAR] <= nearEmpty_reg;
                        rdata_reg[`ST_FAULT] <= faultSticky_reg;
                        rdata_reg[`ST_CNT_LSB +: AW+1] <= storeCount;
                    end
                    default: rresp_reg <= `RESP_SLVERR;
                endcase
            end
            if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign rdData = rdData_reg;
    assign emptyFlag = empty_reg;
    assign nearEmptyFlag = nearEmpty_reg;
    assign rdFault = rdFault_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rvalid = rvalid_reg;
endmodule // dual_clock_fifo_read_side

// ==== dv/fifo_read_side_properties.sv ====
// Port-level checks on the FIFO read side, output stage and bus.
// Assumes one clock domain, mclk, and bind onto the block's top.
`timescale 1ns/1ps
module fifo_read_side_checker #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Stream
    input wire wrValid,
    input wire wrReady,
    input wire rdReq,
    input wire holdEn,
    input wire loadInit,
    input wire [WIDTH-1:0] rdData,
    input wire emptyFlag,
    input wire nearEmptyFlag,
    input wire rdFault,
    // Bus
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_fault_pulse: assert property (rdReq && emptyFlag |=> rdFault)
        else $error("fault pulse missing after refused read");
    a_fault_cause: assert property (rdFault |-> $past(rdReq && emptyFlag))
        else $error("fault pulse without refused read");
    a_refused_keeps: assert property (rdReq && emptyFlag && !loadInit ##1 emptyFlag
        |-> $stable(rdData)) else $error("refused read changed output");
    a_empty_lag: assert property ($fell(emptyFlag) |-> $past(wrValid && wrReady, 4))
        else $error("empty cleared without push four edges earlier");
    a_near_lag: assert property ($fell(nearEmptyFlag) |-> $past(wrValid && wrReady, 4))
        else $error("near-empty cleared without push four edges earlier");
    a_idle_holds: assert property (!rdReq && !loadInit && !emptyFlag |=> $stable(rdData))
        else $error("output changed without request");
    a_hold_low: assert property (rdReq && !holdEn && !loadInit && !emptyFlag
        |=> $stable(rdData)) else $error("output changed with hold enable low");
    a_empty_rise: assert property ($rose(emptyFlag) |-> $past(rdReq && !emptyFlag))
        else $error("empty rose without a pop");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    c_refused: cover property (rdReq && emptyFlag);
    c_fill: cover property ($fell(emptyFlag));
    c_hold_low: cover property (rdReq && !holdEn && !emptyFlag);
endmodule // fifo_read_side_checker

bind dual_clock_fifo_read_side fifo_read_side_checker #(.WIDTH(WIDTH)) chk_u (
    .mclk(mclk), .rstn(rstn), .wrValid(wrValid), .wrReady(wrReady), .rdReq(rdReq),
    .holdEn(holdEn), .loadInit(loadInit), .rdData(rdData), .emptyFlag(emptyFlag),
    .nearEmptyFlag(nearEmptyFlag), .rdFault(rdFault), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ==== dv/fifo_writer_model.sv ====
// Writer logic that fills the FIFO, promptly or with idle gaps.
// Assumes the bench calls push from its own sequence on mclk.
`timescale 1ns/1ps
module fifo_writer_model #(
    parameter WIDTH = 32
) (
    // Clock
    input wire mclk,
    // Fill stream
    input wire wrReady,
    output logic wrValid,
    output logic [WIDTH-1:0] wrData
);
    initial begin
        wrValid = 1'b0;
        wrData = '0;
    end

    task push(input int n, input logic [WIDTH-1:0] base, input int gap);
        @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            wrValid <= 1'b1;
            wrData <= base + i;
            do @(posedge mclk); while (!wrReady);
            if (gap != 0 || i == n - 1) begin
                wrValid <= 1'b0;
                // Released data is inverted so a late sample shows up
                wrData <= ~wrData;
                repeat (gap) @(posedge mclk);
            end
        end
    endtask
endmodule // fifo_writer_model

// ==== dv/dual_clock_fifo_read_side_tb.sv ====
// Self-checking bench for the FIFO read side and its registers.
// Assumes one 50 MHz clock and the writer model on the fill stream.
`timescale 1ns/1ps
`include "fifo_read_side_consts.vh"
module dual_clock_fifo_read_side_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic rdReq = 1'b0;
    logic holdEn = 1'b0;
    logic loadInit = 1'b0;
    logic [3:0] awAddr = 4'h0;
    logic [3:0] arAddr = 4'h0;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'b0;
    logic wValid = 1'b0;
    logic arValid = 1'b0;
    logic [3:0] wStrb = 4'hf;
    logic bReady = 1'b0;
    logic rReady = 1'b0;
    wire awReady, wReady, bValid, arReady, rValid, wrValid, wrReady;
    wire emptyFlag, nearEmptyFlag, rdFault;
    wire [1:0] bResp, rResp;
    wire [31:0] rData, wrData, rdData;
    int n_errors = 0;
    int compares = 0;

    always #10 mclk = ~mclk;

    fifo_writer_model #(.WIDTH(32)) writer_u (.mclk(mclk), .wrReady(wrReady),
        .wrValid(wrValid), .wrData(wrData));

    dual_clock_fifo_read_side #(.WIDTH(32), .DEPTH(4)) dut_u (.mclk(mclk), .rstn(rstn),
        .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .rdReq(rdReq),
        .holdEn(holdEn), .loadInit(loadInit), .rdData(rdData), .emptyFlag(emptyFlag),
        .nearEmptyFlag(nearEmptyFlag), .rdFault(rdFault), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task finish_test;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Response ready is held until the response is seen, then dropped
    task axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rexp);
        @(posedge mclk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge mclk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        chk(bResp, rexp);
    endtask

    task axiRd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge mclk);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        chk(rResp, rexp);
        if (rexp == `RESP_OKAY) chk(rData, exp);
    endtask

    task rd(input logic h);
        @(posedge mclk);
        rdReq <= 1'b1;
        holdEn <= h;
        @(posedge mclk);
        rdReq <= 1'b0;
        #1;
    endtask

    task rdSeq(input int n, input logic [31:0] first);
        @(posedge mclk);
        rdReq <= 1'b1;
        holdEn <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            if (i == n - 1) rdReq <= 1'b0;
            #1 chk(rdData, first + i);
        end
    endtask

    task emptyLag;
        repeat (2) @(posedge mclk);
        #1 chk(emptyFlag, 1'b1);
        @(posedge mclk);
        #1 chk(emptyFlag, 1'b0);
    endtask

    task ldInit;
        @(posedge mclk);
        loadInit <= 1'b1;
        @(posedge mclk);
        loadInit <= 1'b0;
        #1 chk(rdData, 32'hcafe_0001);
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        finish_test;
    end

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        axiRd(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
        axiRd(`OFS_THRESH, `THRESH_RESET, `RESP_OKAY);
        axiRd(`OFS_INITVAL, `INITVAL_RESET, `RESP_OKAY);
        axiRd(`OFS_STATUS, 32'h0000_0003, `RESP_OKAY);
        axiRd(4'h2, 32'h0, `RESP_SLVERR);
        rd(1'b1);
        chk(rdFault, 1'b1);
        chk(rdData, 32'h0);
        axiRd(`OFS_STATUS, 32'h0000_0007, `RESP_OKAY);
        // Without the low byte lane the clear must not take
        wStrb <= 4'he;
        axiWr(`OFS_STATUS, 32'h0000_0004, `RESP_OKAY);
        axiRd(`OFS_STATUS, 32'h0000_0007, `RESP_OKAY);
        wStrb <= 4'hf;
        axiWr(`OFS_STATUS, 32'h0000_0004, `RESP_OKAY);
        axiRd(`OFS_STATUS, 32'h0000_0003, `RESP_OKAY);
        axiWr(4'h2, 32'hffff_ffff, `RESP_SLVERR);
        axiWr(`OFS_THRESH, 32'h0000_0002, `RESP_OKAY);
        axiRd(`OFS_THRESH, 32'h0000_0002, `RESP_OKAY);
        axiWr(`OFS_INITVAL, 32'hcafe_0001, `RESP_OKAY);
        // Request mode: fill until refused, then drain
        writer_u.push(1, 32'h100, 0);
        emptyLag;
        writer_u.push(3, 32'h101, 0);
        #1 chk(wrReady, 1'b0);
        repeat (4) @(posedge mclk);
        holdEn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(rdData, 32'h0);
        chk(nearEmptyFlag, 1'b0);
        axiRd(`OFS_STATUS, 32'h0000_0400, `RESP_OKAY);
        rdSeq(2, 32'h100);
        chk(nearEmptyFlag, 1'b1);
        rd(1'b0);
        chk(rdData, 32'h101);
        rd(1'b1);
        chk(rdData, 32'h103);
        chk(emptyFlag, 1'b1);
        ldInit;
        rd(1'b1);
        chk(rdFault, 1'b1);
        chk(rdData, 32'hcafe_0001);
        // Fall-through mode, with a slow writer
        axiWr(`OFS_CTRL, 32'hffff_ffff, `RESP_OKAY);
        axiRd(`OFS_CTRL, 32'h0000_0001, `RESP_OKAY);
        writer_u.push(1, 32'h200, 0);
        emptyLag;
        chk(rdData, 32'h200);
        repeat (4) @(posedge mclk);
        writer_u.push(4, 32'h201, 2);
        #1 chk(wrReady, 1'b0);
        repeat (4) @(posedge mclk);
        rdSeq(4, 32'h201);
        rd(1'b1);
        chk(emptyFlag, 1'b1);
        ldInit;
        // Reset in mid-run returns the output stage and registers to idle
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        axiRd(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
        chk(rdData, 32'h0);
        chk(emptyFlag, 1'b1);
        chk(wrReady, 1'b1);
        finish_test;
    end
endmodule // dual_clock_fifo_read_side_tb
